// ---- pkg/card_mux_defs.svh ----
// Purpose: offsets, reset values and timing counts of the card port mux
// Assumes: 8-bit register port, 40 MHz clk
// Notes: definitions only
`ifndef CARD_MUX_DEFS_SVH
`define CARD_MUX_DEFS_SVH

// ****************************************
// register offsets
// ****************************************
`define OFS_CTRL 8'h00
`define OFS_CCR 8'h04
`define OFS_J_DATA 8'h08
`define OFS_J_DIR 8'h0c
`define OFS_M_DATA 8'h10
`define OFS_M_DIR 8'h14
`define OFS_P_DATA 8'h18
`define OFS_P_DIR 8'h1c
`define OFS_PORT_E 8'h20
`define OFS_MISC 8'h24
`define OFS_STATUS 8'h28
`define OFS_MASK 8'h2c

// ****************************************
// field positions and reset values
// ****************************************
`define CTRL_SERIAL_EN 0
`define CTRL_SD_EN 1
`define CTRL_NAND_EN 2
`define CTRL_ALT_SEL 3
`define CTRL_PULLUP 4
`define CTRL_RESET 5'h10
`define ST_NMI 0
`define ST_DETECT 1
`define FILT_RESET 18'h20000
`define STRAP_WAIT 3'h4

`endif

// ---- pkg/card_mux_pkg.sv ----
// Purpose: state types of the card port mux
// Assumes: widths of ports J, M and P as built
// Notes: one packed struct holds all state except the input filter's
package card_mux_pkg;

  typedef struct packed {
    logic [4:0] ctrl;
    logic x_mask;
    logic [2:0] j_dat;
    logic [2:0] j_dir;
    logic [5:0] m_dat;
    logic [5:0] m_dir;
    logic [7:0] p_dat;
    logic [7:0] p_dir;
    logic rom_en;
    logic [2:0] strap_cnt;
    logic strap_done;
    logic [1:0] status;
    logic [1:0] mask;
    logic [7:0] rdata;
    logic [2:0] j_out;
    logic [2:0] j_oe;
    logic [5:0] m_out;
    logic [5:0] m_oe;
    logic [7:0] p_out;
    logic [7:0] p_oe;
    logic nmi_last;
    logic cd_last;
  } mux_state_t;

endpackage

// ---- pkg/pin_sync_if.sv ----
// Purpose: raw pin levels in, filtered levels out
// Assumes: one clock
// Notes: used between the mux and its input filter
`timescale 1ns/1ps
interface pin_sync_if #(parameter int W = 18);
  logic [W-1:0] raw;
  logic [W-1:0] clean;
  modport filt (input raw, output clean);
  modport user (output raw, input clean);
endinterface

// ---- hw/pin_filter.sv ----
// Purpose: three-stage input filter for pins
// Assumes: pins are asynchronous to clk
// Notes: a bit changes once stages two and three agree
`timescale 1ns/1ps
module pin_filter
  import card_mux_pkg::*;
#(
  parameter int W = 18,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // pins
  pin_sync_if.filt pins
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] clean;
  } filt_state_t;

  filt_state_t st_reg;
  filt_state_t st_next;

  if (W < 1) begin : g_chk
    $error("pin_filter width must be at least one");
  end

  always_comb begin
    st_next = st_reg;
    st_next.s1 = pins.raw;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    st_next.clean = (st_reg.s2 & st_reg.s3) | (st_reg.clean & (st_reg.s2 ^ st_reg.s3));
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_reg <= {RESET_VAL, RESET_VAL, RESET_VAL, RESET_VAL};
    end else begin
      st_reg <= st_next;
    end
  end

  assign pins.clean = st_reg.clean;

endmodule

// ---- hw/card_port_pin_function_mux.sv ----
// Purpose: pin function mux for the nmi input and ports J, M and P
// Assumes: card hosts follow the enables held in the control register
// Notes: pin outputs and enables are registered, one cycle behind
//
// What this block does
// - the nmi pin is input only and its level is always readable.
// - the nmi mask bit is set by reset and only software clears it.
// - the nmi request follows a low level on the pin, not an edge.
// - the nmi pull-up is on from reset until software clears its enable.
// - in expanded modes port J bit 2 is caught after reset as the rom enable.
// - with the serial card host on, J2 carries its serial clock.
// - with the serial card host on, J1 carries its two-way data line.
// - with the serial card host on, J0 carries its bus state line.
// - with the sd host on, M5..M2 carry card data bits 3..0.
// - with the sd host on, M1 carries the card clock.
// - with the sd host on, M0 carries the two-way command line.
// - with the nand host on, P7..P0 carry re, we, ale, cle, wp, ce, cd, busy.
// - alternate routing puts high data bit n+8 on P pin n.
// - the nand host wins port P; alternate routing only when it is off.
// - all J, M and P pins are undriven inputs in and just after reset.
// - every unclaimed pin is a software general-purpose pin.
`timescale 1ns/1ps
`include "card_mux_defs.svh"
module card_port_pin_function_mux
  import card_mux_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // cpu side
  input wire logic expanded_mode,
  output logic nmi_request,
  output logic irq,
  // nmi pin
  input wire logic nonmaskable_irq_pin,
  output logic port_e_pullup_enable,
  // port pins
  input wire logic [2:0] port_j_in,
  output logic [2:0] port_j_out,
  output logic [2:0] port_j_oe,
  input wire logic [5:0] port_m_in,
  output logic [5:0] port_m_out,
  output logic [5:0] port_m_oe,
  input wire logic [7:0] port_p_in,
  output logic [7:0] port_p_out,
  output logic [7:0] port_p_oe,
  // serial card host
  input wire logic serial_card_clock,
  input wire logic serial_card_data_o,
  input wire logic serial_card_data_oe,
  output logic serial_card_data_i,
  input wire logic serial_card_bus_state,
  // sd card host
  input wire logic sd_card_clock,
  input wire logic sd_card_command_o,
  input wire logic sd_card_command_oe,
  output logic sd_card_command_i,
  input wire logic [3:0] sd_card_data_lines_o,
  input wire logic sd_card_data_lines_oe,
  output logic [3:0] sd_card_data_lines_i,
  // nand card host
  input wire logic nand_card_read_enable,
  input wire logic nand_card_write_enable,
  input wire logic nand_card_addr_latch,
  input wire logic nand_card_cmd_latch,
  input wire logic nand_card_write_protect,
  input wire logic nand_card_chip_enable,
  output logic nand_card_detect,
  output logic nand_card_busy,
  // alternate high data byte
  input wire logic [7:0] alt_data_o,
  input wire logic alt_data_oe,
  output logic [7:0] alt_data_i
);

  mux_state_t st_reg;
  mux_state_t st_next;
  logic [17:0] clean;
  logic nmi_clean;
  logic [2:0] j_clean;
  logic [5:0] m_clean;
  logic [7:0] p_clean;
  logic serial_en;
  logic sd_en;
  logic nand_en;
  logic alt_en;

  if (ADDR_W < 6) begin : g_chk
    $error("register address too narrow for the map");
  end

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
    hit = (a == ADDR_W'(ofs));
  endfunction

  function automatic logic [7:0] port_read(input logic [7:0] dat, input logic [7:0] dir,
                                           input logic [7:0] pin);
    port_read = (dat & dir) | (pin & ~dir);
  endfunction

  // ****************************************
  // input filter
  // ****************************************
  pin_sync_if #(.W(18)) sync_bus ();

  assign sync_bus.raw = {nonmaskable_irq_pin, port_p_in, port_m_in, port_j_in};
  assign clean = sync_bus.clean;
  assign j_clean = clean[2:0];
  assign m_clean = clean[8:3];
  assign p_clean = clean[16:9];
  assign nmi_clean = clean[17];

  pin_filter #(
    .W(18),
    .RESET_VAL(`FILT_RESET)
  ) u_filter (
    .clk(clk),
    .resetn(resetn),
    .pins(sync_bus)
  );

  assign serial_en = st_reg.ctrl[`CTRL_SERIAL_EN];
  assign sd_en = st_reg.ctrl[`CTRL_SD_EN];
  assign nand_en = st_reg.ctrl[`CTRL_NAND_EN];
  assign alt_en = st_reg.ctrl[`CTRL_ALT_SEL] & ~nand_en;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    st_next = st_reg;
    st_next.rdata = 8'h00;
    st_next.nmi_last = nmi_clean;
    st_next.cd_last = p_clean[1];

    // register writes
    if (reg_wr) begin
      if (hit(reg_addr, `OFS_CTRL)) begin
        st_next.ctrl = reg_wdata[4:0];
      end
      if (hit(reg_addr, `OFS_CCR) && !reg_wdata[0]) begin
        st_next.x_mask = 1'b0;
      end
      if (hit(reg_addr, `OFS_J_DATA)) begin
        st_next.j_dat = reg_wdata[2:0];
      end
      if (hit(reg_addr, `OFS_J_DIR)) begin
        st_next.j_dir = reg_wdata[2:0];
      end
      if (hit(reg_addr, `OFS_M_DATA)) begin
        st_next.m_dat = reg_wdata[5:0];
      end
      if (hit(reg_addr, `OFS_M_DIR)) begin
        st_next.m_dir = reg_wdata[5:0];
      end
      if (hit(reg_addr, `OFS_P_DATA)) begin
        st_next.p_dat = reg_wdata;
      end
      if (hit(reg_addr, `OFS_P_DIR)) begin
        st_next.p_dir = reg_wdata;
      end
      if (hit(reg_addr, `OFS_MASK)) begin
        st_next.mask = reg_wdata[1:0];
      end
    end

    // register reads, data one cycle later
    if (reg_rd) begin
      case (1'b1)
        hit(reg_addr, `OFS_CTRL): st_next.rdata = {3'h0, st_reg.ctrl};
        hit(reg_addr, `OFS_CCR): st_next.rdata = {7'h00, st_reg.x_mask};
        hit(reg_addr, `OFS_J_DATA): begin
          st_next.rdata = port_read({5'h00, st_reg.j_dat}, {5'h00, st_reg.j_dir},
                                    {5'h00, j_clean});
        end
        hit(reg_addr, `OFS_J_DIR): st_next.rdata = {5'h00, st_reg.j_dir};
        hit(reg_addr, `OFS_M_DATA): begin
          st_next.rdata = port_read({2'h0, st_reg.m_dat}, {2'h0, st_reg.m_dir},
                                    {2'h0, m_clean});
        end
        hit(reg_addr, `OFS_M_DIR): st_next.rdata = {2'h0, st_reg.m_dir};
        hit(reg_addr, `OFS_P_DATA): begin
          st_next.rdata = port_read(st_reg.p_dat, st_reg.p_dir, p_clean);
        end
        hit(reg_addr, `OFS_P_DIR): st_next.rdata = st_reg.p_dir;
        hit(reg_addr, `OFS_PORT_E): st_next.rdata = {7'h00, nmi_clean};
        hit(reg_addr, `OFS_MISC): st_next.rdata = {6'h00, st_reg.strap_done, st_reg.rom_en};
        hit(reg_addr, `OFS_STATUS): st_next.rdata = {6'h00, st_reg.status};
        hit(reg_addr, `OFS_MASK): st_next.rdata = {6'h00, st_reg.mask};
        default: st_next.rdata = 8'h00;
      endcase
    end

    // sticky events, a read clears but a new event wins
    if (reg_rd && hit(reg_addr, `OFS_STATUS)) begin
      st_next.status = 2'h0;
    end
    if (st_reg.nmi_last && !nmi_clean) begin
      st_next.status[`ST_NMI] = 1'b1;
    end
    if (nand_en && (st_reg.cd_last != p_clean[1])) begin
      st_next.status[`ST_DETECT] = 1'b1;
    end

    // rom enable strap, taken once the filter has settled
    if (!st_reg.strap_done) begin
      st_next.strap_cnt = st_reg.strap_cnt + 3'h1;
      if (st_reg.strap_cnt == `STRAP_WAIT) begin
        st_next.strap_done = 1'b1;
        st_next.rom_en = expanded_mode ? j_clean[2] : 1'b1;
      end
    end

    // port J: general purpose unless the serial host claims it
    st_next.j_out = st_reg.j_dat;
    st_next.j_oe = st_reg.j_dir;
    if (serial_en) begin
      st_next.j_out[2] = serial_card_clock;
      st_next.j_oe[2] = 1'b1;
      st_next.j_out[1] = serial_card_data_o;
      st_next.j_oe[1] = serial_card_data_oe;
      st_next.j_out[0] = serial_card_bus_state;
      st_next.j_oe[0] = 1'b1;
    end

    // port M: general purpose unless the sd host claims it
    st_next.m_out = st_reg.m_dat;
    st_next.m_oe = st_reg.m_dir;
    if (sd_en) begin
      st_next.m_out[5:2] = sd_card_data_lines_o;
      st_next.m_oe[5:2] = {4{sd_card_data_lines_oe}};
      st_next.m_out[1] = sd_card_clock;
      st_next.m_oe[1] = 1'b1;
      st_next.m_out[0] = sd_card_command_o;
      st_next.m_oe[0] = sd_card_command_oe;
    end

    // port P: nand host first, then alternate data, then general purpose
    st_next.p_out = st_reg.p_dat;
    st_next.p_oe = st_reg.p_dir;
    if (nand_en) begin
      st_next.p_out[7:2] = {nand_card_read_enable, nand_card_write_enable,
                            nand_card_addr_latch, nand_card_cmd_latch,
                            nand_card_write_protect, nand_card_chip_enable};
      st_next.p_oe = 8'hfc;
      st_next.p_out[1:0] = 2'h0;
    end else if (alt_en) begin
      st_next.p_out = alt_data_o;
      st_next.p_oe = {8{alt_data_oe}};
    end
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_reg <= '0;
      st_reg.ctrl <= `CTRL_RESET;
      st_reg.x_mask <= 1'b1;
      st_reg.nmi_last <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign reg_rdata = st_reg.rdata;
  assign nmi_request = ~nmi_clean & ~st_reg.x_mask;
  assign irq = |(st_reg.status & st_reg.mask);
  assign port_e_pullup_enable = st_reg.ctrl[`CTRL_PULLUP];
  assign port_j_out = st_reg.j_out;
  assign port_j_oe = st_reg.j_oe;
  assign port_m_out = st_reg.m_out;
  assign port_m_oe = st_reg.m_oe;
  assign port_p_out = st_reg.p_out;
  assign port_p_oe = st_reg.p_oe;
  assign serial_card_data_i = j_clean[1];
  assign sd_card_command_i = m_clean[0];
  assign sd_card_data_lines_i = m_clean[5:2];
  assign nand_card_detect = p_clean[1];
  assign nand_card_busy = p_clean[0];
  assign alt_data_i = p_clean;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  a_port_e_read: assert property (
    reg_rd && hit(reg_addr, `OFS_PORT_E) |=> reg_rdata == {7'h00, $past(nmi_clean)})
    else $error("port e read does not show the nmi pin");

  a_mask_clear_cause: assert property (
    $fell(st_reg.x_mask) |-> $past(reg_wr && hit(reg_addr, `OFS_CCR) && !reg_wdata[0]))
    else $error("nmi mask cleared without a write");

  a_nmi_low_level: assert property (
    (!nonmaskable_irq_pin && !st_reg.x_mask) [*5] |-> nmi_request)
    else $error("nmi request not held for a low level");

  a_pullup_drop: assert property (
    $fell(port_e_pullup_enable) |-> $past(reg_wr && hit(reg_addr, `OFS_CTRL)))
    else $error("pull-up removed without a write");

  a_strap_capture: assert property (
    $rose(st_reg.strap_done) && $past(expanded_mode) |-> st_reg.rom_en == $past(j_clean[2]))
    else $error("rom enable not taken from port j bit 2");

  a_serial_route: assert property (
    serial_en && $past(serial_en) |=> port_j_oe[2] && port_j_oe[0]
      && port_j_out[2] == $past(serial_card_clock))
    else $error("serial clock not routed to port j");

  a_sd_data_route: assert property (
    sd_en |=> port_m_out[5:2] == $past(sd_card_data_lines_o)
      && port_m_oe[5:2] == {4{$past(sd_card_data_lines_oe)}})
    else $error("sd data not routed to port m");

  a_nand_priority: assert property (
    nand_en |=> port_p_oe == 8'hfc && port_p_out[7] == $past(nand_card_read_enable))
    else $error("nand host does not own port p");

  a_alt_route: assert property (
    alt_en |=> port_p_out == $past(alt_data_o) && port_p_oe == {8{$past(alt_data_oe)}})
    else $error("alternate data not routed to port p");

  a_gpio_return: assert property (
    !serial_en && !sd_en ##1 !serial_en && !sd_en |-> port_j_oe == $past(st_reg.j_dir)
      && port_m_out == $past(st_reg.m_dat))
    else $error("unclaimed pins not under software control");

endmodule

// ---- verification/card_slot_model.sv ----
// Purpose: memory cards and nmi sources on the far side of the pins
// Assumes: the device wins a pin whenever its output enable is high
// Notes: an undriven line with no pull-up toggles every clock
`timescale 1ns/1ps
module card_slot_model (
  // clock
  input wire logic clk,
  // device pins
  input wire logic [2:0] port_j_out,
  input wire logic [2:0] port_j_oe,
  input wire logic [5:0] port_m_out,
  input wire logic [5:0] port_m_oe,
  input wire logic [7:0] port_p_out,
  input wire logic [7:0] port_p_oe,
  input wire logic port_e_pullup_enable,
  // card drive, bits j 2:0, m 8:3, p 16:9
  input wire logic [16:0] card_en,
  input wire logic [16:0] card_val,
  input wire logic [1:0] nmi_low,
  // levels seen by the device
  output logic [2:0] port_j_in,
  output logic [5:0] port_m_in,
  output logic [7:0] port_p_in,
  output logic nonmaskable_irq_pin
);
  logic float_reg = 1'b0;
  logic [16:0] lvl;
  logic [16:0] dev_out;
  logic [16:0] dev_oe;

  always @(posedge clk) float_reg <= ~float_reg;
  assign dev_out = {port_p_out, port_m_out, port_j_out};
  assign dev_oe = {port_p_oe, port_m_oe, port_j_oe};
  always_comb begin
    for (int i = 0; i < 17; i++) begin
      lvl[i] = dev_oe[i] ? dev_out[i] : (card_en[i] ? card_val[i] : float_reg);
    end
  end
  assign {port_p_in, port_m_in, port_j_in} = lvl;
  // open-drain sources share the line, pull-up holds it high otherwise
  assign nonmaskable_irq_pin = (|nmi_low) ? 1'b0 : (port_e_pullup_enable ? 1'b1 : float_reg);
endmodule

// ---- verification/card_port_pin_function_mux_bench.sv ----
// Purpose: self-checking bench of the card port pin mux
// Assumes: card slot model on the pins
// Notes: one task per scenario
`timescale 1ns/1ps
`include "card_mux_defs.svh"
module card_port_pin_function_mux_bench import card_mux_pkg::*;;
  logic clk, resetn, reg_wr, reg_rd, expanded_mode, nmi_request, irq, alt_data_oe;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, port_p_in, port_p_out, port_p_oe;
  logic [7:0] alt_data_o, alt_data_i;
  logic [2:0] port_j_in, port_j_out, port_j_oe;
  logic [5:0] port_m_in, port_m_out, port_m_oe;
  logic nonmaskable_irq_pin, port_e_pullup_enable, serial_card_clock, serial_card_data_o;
  logic serial_card_data_oe, serial_card_data_i, serial_card_bus_state, sd_card_clock;
  logic sd_card_command_o, sd_card_command_oe, sd_card_command_i, sd_card_data_lines_oe;
  logic [3:0] sd_card_data_lines_o, sd_card_data_lines_i;
  logic nand_card_read_enable, nand_card_write_enable, nand_card_addr_latch;
  logic nand_card_cmd_latch, nand_card_write_protect, nand_card_chip_enable;
  logic nand_card_detect, nand_card_busy;
  logic [16:0] card_en, card_val;
  logic [1:0] nmi_low;
  int err_count, comparisons, cycles;

`define CHK(got, exp, msg) \
  begin \
    comparisons++; \
    if ((got) !== (exp)) begin \
      err_count++; \
      $display("MISMATCH t=%0t %s", $time, msg); \
    end \
  end

  card_port_pin_function_mux #(.ADDR_W(8)) i_dut (.clk, .resetn, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .expanded_mode, .nmi_request, .irq, .nonmaskable_irq_pin,
    .port_e_pullup_enable, .port_j_in, .port_j_out, .port_j_oe, .port_m_in, .port_m_out,
    .port_m_oe, .port_p_in, .port_p_out, .port_p_oe, .serial_card_clock, .serial_card_data_o,
    .serial_card_data_oe, .serial_card_data_i, .serial_card_bus_state, .sd_card_clock,
    .sd_card_command_o, .sd_card_command_oe, .sd_card_command_i, .sd_card_data_lines_o,
    .sd_card_data_lines_oe, .sd_card_data_lines_i, .nand_card_read_enable,
    .nand_card_write_enable, .nand_card_addr_latch, .nand_card_cmd_latch,
    .nand_card_write_protect, .nand_card_chip_enable, .nand_card_detect, .nand_card_busy,
    .alt_data_o, .alt_data_oe, .alt_data_i);

  card_slot_model i_cards (.clk, .port_j_out, .port_j_oe, .port_m_out, .port_m_oe,
    .port_p_out, .port_p_oe, .port_e_pullup_enable, .card_en, .card_val, .nmi_low,
    .port_j_in, .port_m_in, .port_p_in, .nonmaskable_irq_pin);

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic report_and_stop();
    $display("comparisons=%0d err_count=%0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      err_count++;
      report_and_stop();
    end
  end

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string m);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    `CHK(reg_rdata, e, m);
  endtask

  task automatic do_reset(input logic xm, input logic [7:0] misc);
    @(posedge clk);
    resetn <= 1'b0;
    expanded_mode <= xm;
    step(18);
    `CHK({port_j_oe, port_m_oe, port_p_oe}, 17'h0, "oe in reset");
    `CHK(port_e_pullup_enable, 1'b1, "pullup in reset");
    @(posedge clk) resetn <= 1'b1;
    step(2);
    `CHK({port_j_oe, port_m_oe, port_p_oe}, 17'h0, "oe after reset");
    `CHK(nmi_request, 1'b0, "masked after reset");
    step(8);
    rd(`OFS_MISC, misc, "rom strap");
    rd(`OFS_CCR, 8'h01, "mask after reset");
  endtask

  task automatic t_nmi();
    wr(`OFS_MASK, 8'h00);
    @(posedge clk) nmi_low <= 2'b01;
    step(6);
    rd(`OFS_PORT_E, 8'h00, "pin low");
    `CHK(nmi_request, 1'b0, "request masked");
    `CHK(irq, 1'b0, "status masked");
    wr(`OFS_CCR, 8'h00);
    step(20);
    `CHK(nmi_request, 1'b1, "level request");
    @(posedge clk) nmi_low <= 2'b11;
    @(posedge clk) nmi_low <= 2'b10;
    step(6);
    `CHK(nmi_request, 1'b1, "wired or");
    wr(`OFS_MASK, 8'h01);
    step(1);
    `CHK(irq, 1'b1, "irq unmasked");
    rd(`OFS_STATUS, 8'h01, "nmi event");
    step(1);
    `CHK(irq, 1'b0, "irq cleared");
    rd(`OFS_STATUS, 8'h00, "status cleared");
    @(posedge clk) nmi_low <= 2'b00;
    step(6);
    `CHK(nmi_request, 1'b0, "released");
    rd(`OFS_PORT_E, 8'h01, "pin high");
    wr(`OFS_CCR, 8'h01);
    rd(`OFS_CCR, 8'h00, "mask not settable");
    wr(`OFS_CTRL, 8'h00);
    step(2);
    `CHK(port_e_pullup_enable, 1'b0, "pullup off");
  endtask

  task automatic t_gpio();
    wr(`OFS_J_DIR, 8'h05);
    wr(`OFS_J_DATA, 8'h04);
    wr(`OFS_M_DIR, 8'h3f);
    wr(`OFS_M_DATA, 8'h2a);
    wr(`OFS_P_DIR, 8'h0f);
    wr(`OFS_P_DATA, 8'h96);
    @(posedge clk);
    card_en <= 17'h1e002;
    card_val <= 17'h14002;
    step(6);
    `CHK({port_j_oe, port_j_out & port_j_oe}, 6'h2c, "j gpio");
    `CHK({port_m_oe, port_m_out}, 12'hfea, "m gpio");
    `CHK({port_p_oe, port_p_out & port_p_oe}, 16'h0f06, "p gpio");
    rd(`OFS_J_DATA, 8'h06, "j read");
    rd(`OFS_P_DATA, 8'ha6, "p read");
    wr(8'h30, 8'hff);
    rd(8'h30, 8'h00, "unmapped");
  endtask

  task automatic t_serial();
    @(posedge clk);
    {serial_card_clock, serial_card_data_o, serial_card_data_oe} <= 3'b111;
    serial_card_bus_state <= 1'b1;
    wr(`OFS_CTRL, 8'h01);
    step(2);
    `CHK(port_j_oe, 3'b111, "serial oe");
    `CHK(port_j_out, 3'b111, "serial out");
    @(posedge clk) {serial_card_clock, serial_card_data_oe} <= 2'b00;
    step(6);
    `CHK(port_j_out[2], 1'b0, "serial clock low");
    `CHK(port_j_oe[1], 1'b0, "data released");
    `CHK(serial_card_data_i, 1'b1, "data in");
    wr(`OFS_CTRL, 8'h00);
    step(2);
    `CHK({port_j_oe, port_j_out & port_j_oe}, 6'h2c, "j handed back");
  endtask

  task automatic t_sd();
    @(posedge clk);
    {sd_card_clock, sd_card_command_o, sd_card_command_oe, sd_card_data_lines_oe} <= 4'hf;
    sd_card_data_lines_o <= 4'h5;
    wr(`OFS_CTRL, 8'h02);
    step(2);
    `CHK({port_m_oe, port_m_out}, 12'hfd7, "sd drive");
    @(posedge clk);
    {sd_card_clock, sd_card_command_oe, sd_card_data_lines_oe} <= 3'b000;
    card_en <= 17'h001e8;
    card_val <= 17'h000a0;
    step(6);
    `CHK({port_m_oe, port_m_out[1]}, 7'h04, "sd clock only");
    `CHK(sd_card_data_lines_i, 4'h5, "sd data in");
    `CHK(sd_card_command_i, 1'b0, "sd cmd in");
    wr(`OFS_CTRL, 8'h00);
    step(2);
    `CHK({port_m_oe, port_m_out}, 12'hfea, "m handed back");
  endtask

  task automatic t_port_p();
    @(posedge clk);
    alt_data_o <= 8'h3c;
    alt_data_oe <= 1'b1;
    wr(`OFS_CTRL, 8'h08);
    step(2);
    `CHK({port_p_oe, port_p_out}, 16'hff3c, "alt drive");
    @(posedge clk);
    alt_data_oe <= 1'b0;
    card_en <= 17'h1fe00;
    card_val <= 17'h14a00;
    step(6);
    `CHK(alt_data_i, 8'ha5, "alt in");
    @(posedge clk);
    alt_data_oe <= 1'b1;
    card_en <= 17'h00600;
    card_val <= 17'h00200;
    {nand_card_read_enable, nand_card_write_enable, nand_card_addr_latch} <= 3'b101;
    {nand_card_cmd_latch, nand_card_write_protect, nand_card_chip_enable} <= 3'b010;
    wr(`OFS_MASK, 8'h02);
    wr(`OFS_CTRL, 8'h0c);
    step(6);
    `CHK({port_p_oe, port_p_out[7:2]}, 14'h3f2a, "nand wins");
    `CHK({nand_card_detect, nand_card_busy}, 2'b01, "nand status in");
    @(posedge clk) card_val <= 17'h00400;
    step(6);
    `CHK({nand_card_detect, nand_card_busy, irq}, 3'b101, "card detect event");
    rd(`OFS_STATUS, 8'h02, "detect status");
    wr(`OFS_CTRL, 8'h00);
    step(2);
    `CHK({port_p_oe, port_p_out & port_p_oe}, 16'h0f06, "p handed back");
  endtask

  initial begin
    {resetn, reg_wr, reg_rd, expanded_mode, alt_data_oe, serial_card_clock} = '0;
    {serial_card_data_o, serial_card_data_oe, serial_card_bus_state, sd_card_clock} = '0;
    {sd_card_command_o, sd_card_command_oe, sd_card_data_lines_oe} = '0;
    {nand_card_read_enable, nand_card_write_enable, nand_card_addr_latch} = '0;
    {nand_card_cmd_latch, nand_card_write_protect, nand_card_chip_enable} = '0;
    {reg_addr, reg_wdata, alt_data_o, sd_card_data_lines_o} = '0;
    {card_en, card_val, nmi_low, err_count, comparisons, cycles} = '0;
    do_reset(1'b0, 8'h03);
    t_nmi();
    t_gpio();
    t_serial();
    t_sd();
    t_port_p();
    @(posedge clk);
    card_en <= 17'h00004;
    card_val <= 17'h00000;
    nmi_low <= 2'b01;
    do_reset(1'b1, 8'h02);
    @(posedge clk);
    card_val <= 17'h00004;
    nmi_low <= 2'b00;
    do_reset(1'b1, 8'h03);
    report_and_stop();
  end
endmodule
